// ---- fcecr_top.sv ----
/*
 * nvm controller register block: axi4-lite register slave, access-mode
 * registers, full-erase trigger, operation timer, instruction-cache
 * enable with hit and miss counters, keyed access-port lock.
 * assumes one 200 MHz clock; cache hit/miss pulses and operation
 * requests come from logic on the same clock.
 */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - writing 1 to the erase trigger in erase mode starts full erase; 0 does nothing
// - erase trigger is write-only, bit 0, resets to zero
// - cache_on 0 disables and invalidates cache; 1 enables it
// - cache config resets to zero; profiling_on is its own field
// - hit counter counts hits, is read-write, written zero clears it
// - miss counter counts misses, written zero clears it
// - non-secure mode register accepts only zero or one-hot values
// - lock set only with bit 0 high and the valid key
// - a word write finishes within 43 us
// - a page erase finishes within 87 ms
// - a full erase finishes within 173 ms
// - partial erase setup lasts at most 1.08 ms
// - mode codes: read-only 0, write 1, erase 2, partial erase 4
// - write or erase mode keeps the cache invalidated
// - with profiling on, hits and misses increment their counters
module fcecr_top #(
    parameter int unsigned WRITE_CYCLES      = fcecr_pkg::WRITE_CYC,
    parameter int unsigned PAGE_ERASE_CYCLES = fcecr_pkg::PAGE_ERASE_CYC,
    parameter int unsigned FULL_ERASE_CYCLES = fcecr_pkg::FULL_ERASE_CYC,
    parameter int unsigned PART_SETUP_CYCLES = fcecr_pkg::PART_SETUP_CYC
) (
    // clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // register bus
    input  wire fcecr_pkg::fcecr_axi_req_t axi_req,
    output wire fcecr_pkg::fcecr_axi_rsp_t axi_rsp,
    // operation requests from the write path
    input  wire fcecr_pkg::fcecr_op_req_t  op_req,
    output logic                           op_accept,
    output logic                           op_refused,
    // memory array control
    output fcecr_pkg::fcecr_op_t           nvm_op_q,
    output logic                           nvm_busy_q,
    output logic                           nvm_done_q,
    // instruction cache
    input  wire logic                      icache_hit,
    input  wire logic                      icache_miss,
    output logic                           cache_enable_q,
    output logic                           cache_invalidate_q,
    // debug port protection
    output logic                           access_port_lock_q
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // merge written bytes over the old value
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // mode codes are zero or one-hot
    function automatic logic mode_legal(input logic [31:0] v);
        return (v[31:fcecr_pkg::MODE_W] == '0) && $onehot0(v[fcecr_pkg::MODE_W-1:0]);
    endfunction

    // does a mode allow an operation kind
    function automatic logic mode_allows(input logic [2:0] mode,
                                         input fcecr_pkg::fcecr_op_t kind);
        logic ok;
        ok = 1'b0;
        unique case (kind)
            fcecr_pkg::OP_WRITE_WORD:    ok = (mode == fcecr_pkg::MODE_WRITE_EN);
            fcecr_pkg::OP_PAGE_ERASE:    ok = (mode == fcecr_pkg::MODE_ERASE_EN);
            fcecr_pkg::OP_FULL_ERASE:    ok = (mode == fcecr_pkg::MODE_ERASE_EN);
            fcecr_pkg::OP_PARTIAL_ERASE: ok = (mode == fcecr_pkg::MODE_PARTIAL_EN);
            default:                     ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ------------------------------------------------------------------
    // bus write channel
    // ------------------------------------------------------------------
    logic [11:0] aw_addr_q;
    logic        aw_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        w_held_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_fire;
    logic [11:0] wr_addr;
    logic        wr_hit;

    assign axi_rsp.awready = !aw_held_q && !bvalid_q;
    assign axi_rsp.wready  = !w_held_q && !bvalid_q;
    assign wr_fire         = aw_held_q && w_held_q && !bvalid_q;
    assign wr_addr         = {aw_addr_q[11:2], 2'h0};
    assign wr_hit          = (wr_addr == fcecr_pkg::OFF_ACCESS_MODE)
                          || (wr_addr == fcecr_pkg::OFF_FULL_ERASE)
                          || (wr_addr == fcecr_pkg::OFF_PARTIAL_CFG)
                          || (wr_addr == fcecr_pkg::OFF_ICACHE_CONFIG)
                          || (wr_addr == fcecr_pkg::OFF_ICACHE_HITS)
                          || (wr_addr == fcecr_pkg::OFF_ICACHE_MISSES)
                          || (wr_addr == fcecr_pkg::OFF_NS_MODE)
                          || (wr_addr == fcecr_pkg::OFF_NS_PROTECT);

    // address and data taken in either order, answered once both held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= fcecr_pkg::RESET_ZERO;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= fcecr_pkg::RESP_OKAY;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= axi_req.awaddr;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                w_held_q <= 1'b1;
                w_data_q <= axi_req.wdata;
                w_strb_q <= axi_req.wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_hit ? fcecr_pkg::RESP_OKAY : fcecr_pkg::RESP_SLVERR;
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp  = bresp_q;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [2:0]  mode_q;
    logic [2:0]  ns_mode_q;
    logic [31:0] partial_cfg_q;
    logic        cache_on_q;
    logic        profiling_on_q;
    logic [31:0] wr_val;
    logic        erase_trigger;

    assign wr_val = merge_strb(fcecr_pkg::RESET_ZERO, w_data_q, w_strb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q    <= fcecr_pkg::MODE_READ_ONLY;
            ns_mode_q <= fcecr_pkg::MODE_READ_ONLY;
        end else if (wr_fire && mode_legal(wr_val)) begin
            if (wr_addr == fcecr_pkg::OFF_ACCESS_MODE) begin
                mode_q <= wr_val[fcecr_pkg::MODE_W-1:0];
            end
            if (wr_addr == fcecr_pkg::OFF_NS_MODE) begin
                ns_mode_q <= wr_val[fcecr_pkg::MODE_W-1:0];
            end
        end
    end

    // partial erase configuration, stored and read back only; the engine does not use it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            partial_cfg_q <= fcecr_pkg::RESET_ZERO;
        end else if (wr_fire && wr_addr == fcecr_pkg::OFF_PARTIAL_CFG) begin
            partial_cfg_q <= merge_strb(partial_cfg_q, w_data_q, w_strb_q);
        end
    end

    // cache config reset / cache enable field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cache_on_q     <= 1'b0;
            profiling_on_q <= 1'b0;
        end else if (wr_fire && wr_addr == fcecr_pkg::OFF_ICACHE_CONFIG) begin
            cache_on_q     <= wr_val[fcecr_pkg::BIT_CACHE_ON];
            profiling_on_q <= wr_val[fcecr_pkg::BIT_PROFILE_ON];
        end
    end

    // write-only trigger / only a 1 starts
    assign erase_trigger = wr_fire && (wr_addr == fcecr_pkg::OFF_FULL_ERASE)
                        && wr_val[fcecr_pkg::BIT_TRIGGER];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            access_port_lock_q <= 1'b0;
        end else if (wr_fire && wr_addr == fcecr_pkg::OFF_NS_PROTECT
                     && wr_val[fcecr_pkg::BIT_PROTECT_SET]
                     && wr_val[31:fcecr_pkg::KEY_LSB] == fcecr_pkg::PROTECT_KEY) begin
            access_port_lock_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // operation engine
    // ------------------------------------------------------------------
    typedef enum logic {ENG_IDLE, ENG_RUN} fcecr_eng_t;
    fcecr_eng_t  eng_q;
    logic [31:0] timer_q;
    logic        full_ok;
    logic        req_ok;

    // erase mode required for the trigger
    assign full_ok    = erase_trigger && mode_allows(mode_q, fcecr_pkg::OP_FULL_ERASE);
    assign req_ok     = op_req.valid && mode_allows(op_req.nonsecure ? ns_mode_q : mode_q,
                                                    op_req.kind);
    // software trigger has priority over a path request in the same cycle
    assign op_accept  = (eng_q == ENG_IDLE) && !full_ok && req_ok;
    assign op_refused = op_req.valid && !op_accept;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eng_q      <= ENG_IDLE;
            timer_q    <= '0;
            nvm_op_q   <= fcecr_pkg::OP_NONE;
            nvm_busy_q <= 1'b0;
            nvm_done_q <= 1'b0;
        end else begin
            nvm_done_q <= 1'b0;
            unique case (eng_q)
                ENG_IDLE: begin
                    if (full_ok) begin
                        eng_q      <= ENG_RUN;
                        nvm_op_q   <= fcecr_pkg::OP_FULL_ERASE;
                        nvm_busy_q <= 1'b1;
                        timer_q    <= 32'(FULL_ERASE_CYCLES - 1);
                    end else if (op_accept) begin
                        eng_q      <= ENG_RUN;
                        nvm_op_q   <= op_req.kind;
                        nvm_busy_q <= 1'b1;
                        unique case (op_req.kind)
                            fcecr_pkg::OP_WRITE_WORD: timer_q <= 32'(WRITE_CYCLES - 1);
                            fcecr_pkg::OP_PAGE_ERASE: timer_q <= 32'(PAGE_ERASE_CYCLES - 1);
                            default:                  timer_q <= 32'(PART_SETUP_CYCLES - 1);
                        endcase
                    end
                end
                ENG_RUN: begin
                    if (timer_q == '0) begin
                        eng_q      <= ENG_IDLE;
                        nvm_op_q   <= fcecr_pkg::OP_NONE;
                        nvm_busy_q <= 1'b0;
                        nvm_done_q <= 1'b1;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // instruction cache control and profiling
    // ------------------------------------------------------------------
    logic [31:0] hits_q;
    logic [31:0] misses_q;
    logic        mode_blocks_cache;

    assign mode_blocks_cache = (mode_q != fcecr_pkg::MODE_READ_ONLY)
                            || (ns_mode_q != fcecr_pkg::MODE_READ_ONLY);

    // disable invalidates / held invalid in write or erase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cache_enable_q     <= 1'b0;
            cache_invalidate_q <= 1'b1;
        end else begin
            cache_enable_q     <= cache_on_q && !mode_blocks_cache;
            cache_invalidate_q <= !cache_on_q || mode_blocks_cache;
        end
    end

    // hit counter / count on hit / hold when off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hits_q <= fcecr_pkg::RESET_ZERO;
        end else if (wr_fire && wr_addr == fcecr_pkg::OFF_ICACHE_HITS) begin
            hits_q <= merge_strb(hits_q, w_data_q, w_strb_q);
        end else if (profiling_on_q && icache_hit) begin
            hits_q <= hits_q + 32'h1;
        end
    end

    // miss counter / count on miss / hold when off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            misses_q <= fcecr_pkg::RESET_ZERO;
        end else if (wr_fire && wr_addr == fcecr_pkg::OFF_ICACHE_MISSES) begin
            misses_q <= merge_strb(misses_q, w_data_q, w_strb_q);
        end else if (profiling_on_q && icache_miss) begin
            misses_q <= misses_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // bus read channel
    // ------------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_val;
    logic        rd_hit;
    logic [11:0] rd_addr;

    assign axi_rsp.arready = !rvalid_q;
    assign rd_addr         = {axi_req.araddr[11:2], 2'h0};

    // read decode; write-only registers read as zero
    always_comb begin
        rd_val = fcecr_pkg::RESET_ZERO;
        rd_hit = 1'b1;
        unique case (rd_addr)
            fcecr_pkg::OFF_ACCESS_MODE:   rd_val = 32'(mode_q);
            fcecr_pkg::OFF_NS_MODE:       rd_val = 32'(ns_mode_q);
            fcecr_pkg::OFF_PARTIAL_CFG:   rd_val = partial_cfg_q;
            fcecr_pkg::OFF_ICACHE_HITS:   rd_val = hits_q;
            fcecr_pkg::OFF_ICACHE_MISSES: rd_val = misses_q;
            fcecr_pkg::OFF_FULL_ERASE:    rd_val = fcecr_pkg::RESET_ZERO;
            fcecr_pkg::OFF_NS_PROTECT:    rd_val = fcecr_pkg::RESET_ZERO;
            fcecr_pkg::OFF_ICACHE_CONFIG: begin
                rd_val[fcecr_pkg::BIT_CACHE_ON]   = cache_on_q;
                rd_val[fcecr_pkg::BIT_PROFILE_ON] = profiling_on_q;
            end
            fcecr_pkg::OFF_OP_STATUS: begin
                rd_val[0] = nvm_busy_q;
                rd_val[1] = access_port_lock_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // one read answered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= fcecr_pkg::RESET_ZERO;
            rresp_q  <= fcecr_pkg::RESP_OKAY;
        end else if (axi_req.arvalid && axi_rsp.arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_hit ? fcecr_pkg::RESP_OKAY : fcecr_pkg::RESP_SLVERR;
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata  = rdata_q;
    assign axi_rsp.rresp  = rresp_q;

endmodule

// ---- fcecr_pkg.sv ----
/*
 * shared constants and types for the nvm controller register block:
 * register offsets, field positions, reset values, access-mode codes,
 * operation kinds, bus carrier structs and operation timing limits.
 * assumes a 200 MHz system clock and 12-bit register byte addresses.
 */
package fcecr_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W            = 12;
    localparam logic [11:0] OFF_ACCESS_MODE   = 12'h504;
    localparam logic [11:0] OFF_FULL_ERASE    = 12'h50c;
    localparam logic [11:0] OFF_PARTIAL_CFG   = 12'h51c;
    localparam logic [11:0] OFF_ICACHE_CONFIG = 12'h540;
    localparam logic [11:0] OFF_ICACHE_HITS   = 12'h548;
    localparam logic [11:0] OFF_ICACHE_MISSES = 12'h54c;
    localparam logic [11:0] OFF_NS_MODE       = 12'h584;
    localparam logic [11:0] OFF_NS_PROTECT    = 12'h588;
    localparam logic [11:0] OFF_OP_STATUS     = 12'h5f0;

    // ------------------------------------------------------------------
    // field positions, codes and reset values
    // ------------------------------------------------------------------
    localparam int unsigned MODE_W          = 3;
    localparam logic [2:0]  MODE_READ_ONLY  = 3'h0;
    localparam logic [2:0]  MODE_WRITE_EN   = 3'h1;
    localparam logic [2:0]  MODE_ERASE_EN   = 3'h2;
    localparam logic [2:0]  MODE_PARTIAL_EN = 3'h4;
    localparam int unsigned BIT_TRIGGER     = 0;
    localparam int unsigned BIT_CACHE_ON    = 0;
    localparam int unsigned BIT_PROFILE_ON  = 8;
    localparam int unsigned BIT_PROTECT_SET = 0;
    localparam int unsigned KEY_LSB         = 4;
    localparam logic [27:0] PROTECT_KEY     = 28'hafbe5a7;
    localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ------------------------------------------------------------------
    // operation timing limits (longest times, rounded down to cycles)
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned T_WRITE_US       = 43;
    localparam int unsigned T_PAGE_ERASE_MS  = 87;
    localparam int unsigned T_FULL_ERASE_MS  = 173;
    localparam int unsigned T_PART_SETUP_US  = 1080; // 1.08 ms
    localparam int unsigned WRITE_CYC        = T_WRITE_US * CLK_MHZ;
    localparam int unsigned PAGE_ERASE_CYC   = T_PAGE_ERASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned FULL_ERASE_CYC   = T_FULL_ERASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned PART_SETUP_CYC   = T_PART_SETUP_US * CLK_MHZ;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_WRITE_WORD, OP_PAGE_ERASE, OP_PARTIAL_ERASE, OP_FULL_ERASE
    } fcecr_op_t;

    typedef struct packed {
        logic        valid;
        fcecr_op_t   kind;
        logic        nonsecure;
    } fcecr_op_req_t;

    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } fcecr_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } fcecr_axi_rsp_t;

endpackage

// ---- fcecr_top_chk.sv ----
/*
 * checker for fcecr_top: op lengths, handshake, bus, cache, lock.
 * assumes binding into fcecr_top; sees only its ports.
 */
`timescale 1ns/1ps
module fcecr_top_chk #(
    parameter int unsigned WRITE_CYCLES      = 5,
    parameter int unsigned PAGE_ERASE_CYCLES = 20,
    parameter int unsigned FULL_ERASE_CYCLES = 30,
    parameter int unsigned PART_SETUP_CYCLES = 10
) (
    // clock and reset
    input wire logic                      aclk,
    input wire logic                      aresetn,
    // watched ports
    input wire fcecr_pkg::fcecr_axi_rsp_t axi_rsp,
    input wire fcecr_pkg::fcecr_op_req_t  op_req,
    input wire logic                      op_accept,
    input wire logic                      op_refused,
    input wire fcecr_pkg::fcecr_op_t      nvm_op_q,
    input wire logic                      nvm_busy_q,
    input wire logic                      nvm_done_q,
    input wire logic                      cache_enable_q,
    input wire logic                      cache_invalidate_q,
    input wire logic                      access_port_lock_q
);
    // --------
    // helper: running op length, kind
    // --------
    logic [31:0]          cnt_q;
    fcecr_pkg::fcecr_op_t kind_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q  <= 32'h0;
            kind_q <= fcecr_pkg::OP_NONE;
        end else begin
            cnt_q <= nvm_busy_q ? cnt_q + 32'h1 : 32'h0;
            if (nvm_busy_q) kind_q <= nvm_op_q;
        end
    end
    // expected busy cycles of a kind
    function automatic logic [31:0] lim(input fcecr_pkg::fcecr_op_t k);
        case (k)
            fcecr_pkg::OP_WRITE_WORD:    return WRITE_CYCLES;
            fcecr_pkg::OP_PAGE_ERASE:    return PAGE_ERASE_CYCLES;
            fcecr_pkg::OP_PARTIAL_ERASE: return PART_SETUP_CYCLES;
            default:                     return FULL_ERASE_CYCLES;
        endcase
    endfunction
    // --------
    // assertions
    // --------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    op_len_a: assert property (nvm_done_q |-> cnt_q == lim(kind_q))
        else $error("operation length wrong");
    op_start_a: assert property (op_accept |=> nvm_busy_q && nvm_op_q == $past(op_req.kind))
        else $error("accepted operation did not start");
    acc_cause_a: assert property (op_accept |-> op_req.valid && !nvm_busy_q)
        else $error("accept without idle request");
    busy_refuse_a: assert property (op_req.valid && nvm_busy_q |-> op_refused && !op_accept)
        else $error("request while busy not refused");
    cache_excl_a: assert property (!(cache_enable_q && cache_invalidate_q))
        else $error("cache enabled while invalidated");
    lock_sticky_a: assert property (access_port_lock_q |=> access_port_lock_q)
        else $error("port lock dropped");
    b_wait_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while response pending");
    r_wait_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while data pending");
    full_c: cover property (nvm_done_q && kind_q == fcecr_pkg::OP_FULL_ERASE);
    lock_c: cover property ($rose(access_port_lock_q));
    refuse_c: cover property (op_refused);
endmodule

// ---- test_fcecr_top.sv ----
/*
 * bench for fcecr_top: registers, cache, counters, engine, lock.
 * assumes fcecr_pkg and fcecr_top_chk compiled first.
 */
`timescale 1ns/1ps
module test_fcecr_top;
    logic                      aclk = 1'b0;
    logic                      aresetn = 1'b0;
    fcecr_pkg::fcecr_axi_req_t q = '0;
    fcecr_pkg::fcecr_axi_rsp_t s;
    fcecr_pkg::fcecr_op_req_t  o = '0;
    fcecr_pkg::fcecr_op_t      nop;
    logic                      hit = 1'b0, miss = 1'b0;
    logic                      acc, refd, busy, done, en, inv, lock;
    logic [31:0]               d;
    logic [1:0]                r;
    int                        n_errors = 0;
    int                        checked = 0;
    typedef struct packed {logic [11:0] a; logic [31:0] v, e; logic [1:0] rs;} fcecr_row_t;
    fcecr_row_t rows [11] = '{
        '{12'h540, 32'h101, 32'h101, 2'h0}, '{12'h51c, 32'ha5a51234, 32'ha5a51234, 2'h0},
        '{12'h504, 32'h1, 32'h1, 2'h0}, '{12'h504, 32'h2, 32'h2, 2'h0},
        '{12'h504, 32'h4, 32'h4, 2'h0}, '{12'h504, 32'h3, 32'h4, 2'h0},
        '{12'h504, 32'h0, 32'h0, 2'h0}, '{12'h584, 32'h4, 32'h4, 2'h0},
        '{12'h584, 32'h5, 32'h4, 2'h0}, '{12'h584, 32'h0, 32'h0, 2'h0},
        '{12'h7f0, 32'h1, 32'h0, 2'h2}};
    // --------
    // design, clock, shared tasks
    // --------
    fcecr_top #(.WRITE_CYCLES(5), .PAGE_ERASE_CYCLES(20), .FULL_ERASE_CYCLES(30),
        .PART_SETUP_CYCLES(10)) fcecr_top_i (.aclk(aclk), .aresetn(aresetn),
        .axi_req(q), .axi_rsp(s), .op_req(o), .op_accept(acc), .op_refused(refd),
        .nvm_op_q(nop), .nvm_busy_q(busy), .nvm_done_q(done), .icache_hit(hit),
        .icache_miss(miss), .cache_enable_q(en), .cache_invalidate_q(inv),
        .access_port_lock_q(lock));
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // one write, aw and w together
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        q.awaddr <= a;
        q.wdata <= v;
        q.wstrb <= 4'hf;
        q.awvalid <= 1'b1;
        q.wvalid <= 1'b1;
        q.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s.awready) q.awvalid <= 1'b0;
            if (s.wready) q.wvalid <= 1'b0;
        end while (!s.bvalid);
        r = s.bresp;
        q.bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        q.araddr <= a;
        q.arvalid <= 1'b1;
        q.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s.arready) q.arvalid <= 1'b0;
        end while (!s.rvalid);
        d = s.rdata;
        r = s.rresp;
        q.rready <= 1'b0;
    endtask
    task automatic settle();
        @(posedge aclk);
        #1;
    endtask
    task automatic ws(input logic [11:0] a, input logic [31:0] v);
        wr(a, v);
        settle();
    endtask
    task automatic pulse(input logic h, input int n);
        repeat (n) begin
            @(posedge aclk);
            hit <= h;
            miss <= !h;
            @(posedge aclk);
            hit <= 1'b0;
            miss <= 1'b0;
        end
    endtask
    task automatic op(input fcecr_pkg::fcecr_op_t k, input logic e);
        @(posedge aclk);
        o.valid <= 1'b1;
        o.kind <= k;
        #1 chk(acc, e);
        chk(refd, !e);
        @(posedge aclk);
        o.valid <= 1'b0;
    endtask
    task automatic wdone();
        for (int i = 0; i < 100 && done !== 1'b1; i++) settle();
        chk(done, 1);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // --------
    // tests
    // --------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk({en, inv, lock, busy}, 32'h4);
        rd(12'h540);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].v);
            chk(r, rows[i].rs);
            rd(rows[i].a);
            chk(r, rows[i].rs);
            if (rows[i].rs == 2'h0) chk(d, rows[i].e);
        end
        $display("table test done");
        ws(12'h540, 32'h101);
        chk({en, inv}, 32'h2);
        ws(12'h504, 32'h1);
        chk({en, inv}, 32'h1);
        wr(12'h504, 32'h0);
        ws(12'h584, 32'h2);
        chk({en, inv}, 32'h1);
        wr(12'h584, 32'h0);
        ws(12'h540, 32'h100);
        chk({en, inv}, 32'h1);
        pulse(1'b1, 3);
        pulse(1'b0, 2);
        rd(12'h548);
        chk(d, 32'h3);
        rd(12'h54c);
        chk(d, 32'h2);
        wr(12'h540, 32'h0);
        pulse(1'b1, 1);
        pulse(1'b0, 1);
        rd(12'h548);
        chk(d, 32'h3);
        rd(12'h54c);
        chk(d, 32'h2);
        wr(12'h548, 32'h0);
        rd(12'h548);
        chk(d, 32'h0);
        wr(12'h54c, 32'h0);
        rd(12'h54c);
        chk(d, 32'h0);
        $display("cache test done");
        wr(12'h504, 32'h1);
        ws(12'h50c, 32'h1);
        chk(busy, 0);
        wr(12'h504, 32'h2);
        ws(12'h50c, 32'h0);
        chk(busy, 0);
        ws(12'h50c, 32'h1);
        chk({busy, nop}, {1'b1, fcecr_pkg::OP_FULL_ERASE});
        wdone();
        wr(12'h504, 32'h1);
        op(fcecr_pkg::OP_WRITE_WORD, 1'b1);
        op(fcecr_pkg::OP_WRITE_WORD, 1'b0);
        wdone();
        wr(12'h504, 32'h2);
        op(fcecr_pkg::OP_WRITE_WORD, 1'b0);
        op(fcecr_pkg::OP_PAGE_ERASE, 1'b1);
        wdone();
        wr(12'h504, 32'h4);
        op(fcecr_pkg::OP_PARTIAL_ERASE, 1'b1);
        wdone();
        $display("erase test done");
        ws(12'h588, {28'h1234567, 4'h1});
        chk(lock, 0);
        ws(12'h588, {fcecr_pkg::PROTECT_KEY, 4'h0});
        chk(lock, 0);
        ws(12'h588, {fcecr_pkg::PROTECT_KEY, 4'h1});
        chk(lock, 1);
        $display("lock test done");
        results();
    end
    // watchdog: hang is a mismatch
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule
bind fcecr_top fcecr_top_chk #(.WRITE_CYCLES(WRITE_CYCLES),
    .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES), .FULL_ERASE_CYCLES(FULL_ERASE_CYCLES),
    .PART_SETUP_CYCLES(PART_SETUP_CYCLES)) fcecr_top_chk_i (.*);
